// *** logic/ctl_regs.sv ***
// Purpose: i2c clock timing, self-test crc error counter and frequency select override
// Assumes: register port and event inputs on clk; self-test and strap come from pins
// Notes: one count of the timing registers is 40 ns
`timescale 1ns/1ps
module ctl_regs (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic [7:0] reg_addr,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    input wire logic master_en,
    output logic scl_master_low,
    input wire logic slave_setup_start,
    output logic scl_stretch,
    input wire logic self_test_pin,
    input wire logic crc_error,
    input wire logic freq_strap_pin,
    output logic frequency_range_select
);
    typedef struct packed {
        logic [7:0] high_cnt;
        logic [7:0] low_cnt;
        logic [7:0] err_cnt;
        logic [7:0] ovr;
        logic [7:0] rdata;
        logic test_s1;
        logic test_s2;
        logic test_d;
        logic strap_s1;
        logic strap_s2;
        logic v1;
        logic v2;
        logic strap_taken;
        logic strap_val;
        logic range_sel;
        ctl_regs_pkg::phase_t phase;
        logic [15:0] m_tmr;
        logic scl_low;
        logic [15:0] s_tmr;
        logic s_hold;
    } state_t;

    state_t st_reg;
    state_t st_next;

    // timer load for a count: cycles less one, zero for a zero count
    function automatic logic [15:0] load_val(input logic [7:0] cnt);
        logic [15:0] c;
        c = 16'(cnt) * 16'(ctl_regs_pkg::UNIT_CYC);
        load_val = (c == 16'h0000) ? 16'h0000 : c - 16'h0001;
    endfunction

    // ****************************************************************
    // next state
    // ****************************************************************
    always_comb begin
        st_next = st_reg;
        st_next.test_s1 = self_test_pin;
        st_next.test_s2 = st_reg.test_s1;
        st_next.test_d = st_reg.test_s2;
        st_next.strap_s1 = freq_strap_pin;
        st_next.strap_s2 = st_reg.strap_s1;
        st_next.v1 = 1'b1;
        st_next.v2 = st_reg.v1;
        if (st_reg.v2 && !st_reg.strap_taken) begin
            st_next.strap_taken = 1'b1;
            st_next.strap_val = st_reg.strap_s2;
        end
        // register writes
        if (reg_wr) begin
            unique case (reg_addr)
                ctl_regs_pkg::ADDR_CLOCK_HIGH: st_next.high_cnt = reg_wdata;
                ctl_regs_pkg::ADDR_CLOCK_LOW: st_next.low_cnt = reg_wdata;
                ctl_regs_pkg::ADDR_FREQ_OVR: st_next.ovr = reg_wdata;
                default: ;
            endcase
        end
        // register reads
        if (reg_rd) begin
            unique case (reg_addr)
                ctl_regs_pkg::ADDR_CLOCK_HIGH: st_next.rdata = st_reg.high_cnt;
                ctl_regs_pkg::ADDR_CLOCK_LOW: st_next.rdata = st_reg.low_cnt;
                ctl_regs_pkg::ADDR_CRC_ERRORS: st_next.rdata = st_reg.err_cnt;
                ctl_regs_pkg::ADDR_FREQ_OVR: st_next.rdata = st_reg.ovr;
                default: st_next.rdata = 8'h00;
            endcase
        end
        // crc errors, start of a run clears
        if (st_reg.test_s2 && !st_reg.test_d) begin
            st_next.err_cnt = 8'h00;
        end else if (st_reg.test_s2 && crc_error && st_reg.err_cnt != 8'hFF) begin
            st_next.err_cnt = st_reg.err_cnt + 8'h01;
        end
        // frequency select source
        if (st_reg.ovr[ctl_regs_pkg::OVR_EN_BIT]) begin
            st_next.range_sel = st_reg.ovr[ctl_regs_pkg::OVR_VAL_BIT];
        end else begin
            st_next.range_sel = st_next.strap_val;
        end
        // master clock generator
        unique case (st_reg.phase)
            ctl_regs_pkg::PH_IDLE: begin
                st_next.scl_low = 1'b0;
                if (master_en) begin
                    st_next.phase = ctl_regs_pkg::PH_LOW;
                    st_next.scl_low = 1'b1;
                    st_next.m_tmr = load_val(st_reg.low_cnt);
                end
            end
            ctl_regs_pkg::PH_LOW: begin
                if (st_reg.m_tmr != 16'h0000) begin
                    st_next.m_tmr = st_reg.m_tmr - 16'h0001;
                end else begin
                    st_next.phase = ctl_regs_pkg::PH_HIGH;
                    st_next.scl_low = 1'b0;
                    st_next.m_tmr = load_val(st_reg.high_cnt);
                end
            end
            ctl_regs_pkg::PH_HIGH: begin
                if (st_reg.m_tmr != 16'h0000) begin
                    st_next.m_tmr = st_reg.m_tmr - 16'h0001;
                end else if (master_en) begin
                    st_next.phase = ctl_regs_pkg::PH_LOW;
                    st_next.scl_low = 1'b1;
                    st_next.m_tmr = load_val(st_reg.low_cnt);
                end else begin
                    st_next.phase = ctl_regs_pkg::PH_IDLE;
                end
            end
            default: begin
                st_next.phase = ctl_regs_pkg::PH_IDLE;
                st_next.scl_low = 1'b0;
            end
        endcase
        // slave data setup stretch
        if (st_reg.s_hold) begin
            if (st_reg.s_tmr != 16'h0000) begin
                st_next.s_tmr = st_reg.s_tmr - 16'h0001;
            end else begin
                st_next.s_hold = 1'b0;
            end
        end else if (slave_setup_start) begin
            st_next.s_hold = 1'b1;
            st_next.s_tmr = load_val(st_reg.low_cnt);
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            st_reg <= '0;
            st_reg.high_cnt <= ctl_regs_pkg::RST_CLOCK_HIGH;
            st_reg.low_cnt <= ctl_regs_pkg::RST_CLOCK_LOW;
            st_reg.err_cnt <= ctl_regs_pkg::RST_CRC_ERRORS;
            st_reg.ovr <= ctl_regs_pkg::RST_FREQ_OVR;
            st_reg.phase <= ctl_regs_pkg::PH_IDLE;
        end else begin
            st_reg <= st_next;
        end
    end

    assign reg_rdata = st_reg.rdata;
    assign scl_master_low = st_reg.scl_low;
    assign scl_stretch = st_reg.s_hold;
    assign frequency_range_select = st_reg.range_sel;

    // ****************************************************************
    // checks
    // ****************************************************************
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!arst_n);

    a_low_phase_len: assert property (
        (st_reg.phase == ctl_regs_pkg::PH_IDLE && master_en && st_reg.low_cnt == 8'h03)
        |=> st_reg.scl_low [*6] ##1 !st_reg.scl_low)
        else $error("master low phase length wrong");
    // master_en is looked at in idle and, within the high phase, only when that phase ends
    a_high_phase_len: assert property (
        ($fell(st_reg.scl_low) && st_reg.high_cnt == 8'h02)
        |-> !st_reg.scl_low [*4] ##1 (st_reg.scl_low == $past(master_en)))
        else $error("master high phase length wrong");
    a_slave_setup: assert property (
        (!st_reg.s_hold && slave_setup_start && st_reg.low_cnt == 8'h02)
        |=> st_reg.s_hold [*4] ##1 !st_reg.s_hold)
        else $error("slave setup hold length wrong");
    // a write taken at the first edge may already have changed a count
    a_low_reset_val: assert property (
        ($rose(st_reg.v1) && !$past(reg_wr)) |-> st_reg.low_cnt == 8'hA5 && st_reg.high_cnt == 8'hA1)
        else $error("timing counts not at reset value");
    a_crc_only_test: assert property (
        !st_reg.test_s2 |=> $stable(st_reg.err_cnt))
        else $error("crc counter moved outside self-test");
    a_crc_counts: assert property (
        (st_reg.test_s2 && st_reg.test_d && crc_error && st_reg.err_cnt < 8'hFF)
        |=> st_reg.err_cnt == $past(st_reg.err_cnt) + 8'h01)
        else $error("crc error not counted");
    a_crc_run_clear: assert property (
        (st_reg.test_s2 && !st_reg.test_d) |=> st_reg.err_cnt == 8'h00)
        else $error("crc counter not cleared at run start");
    a_range_override: assert property (
        st_reg.ovr[ctl_regs_pkg::OVR_EN_BIT]
        |=> frequency_range_select == $past(st_reg.ovr[ctl_regs_pkg::OVR_VAL_BIT]))
        else $error("override value not applied");
    a_range_strap: assert property (
        (!st_reg.ovr[ctl_regs_pkg::OVR_EN_BIT] && st_reg.strap_taken) |=> frequency_range_select == st_reg.strap_val)
        else $error("strap not used without override");
    a_read_data: assert property (
        (reg_rd && reg_addr == ctl_regs_pkg::ADDR_CRC_ERRORS) |=> reg_rdata == $past(st_reg.err_cnt))
        else $error("read data wrong");

    c_master_cycle: cover property (st_reg.phase == ctl_regs_pkg::PH_HIGH ##1 st_reg.scl_low);
    c_slave_release: cover property ($fell(st_reg.s_hold));
    c_crc_count: cover property (st_reg.test_s2 && st_reg.err_cnt == 8'h02);
    c_override_on: cover property ($rose(st_reg.ovr[7]));
endmodule

// *** logic/ctl_regs_pkg.sv ***
// Purpose: constants for the i2c timing, self-test error and frequency override registers
// Assumes: 50 MHz system clock
// Notes: offsets are byte addresses on the serial control register port
package ctl_regs_pkg;
    // ****************************************************************
    // register map
    // ****************************************************************
    localparam logic [7:0] ADDR_CLOCK_HIGH = 8'h18;
    localparam logic [7:0] ADDR_CLOCK_LOW = 8'h19;
    localparam logic [7:0] ADDR_CRC_ERRORS = 8'h1B;
    localparam logic [7:0] ADDR_FREQ_OVR = 8'h35;
    localparam logic [7:0] RST_CLOCK_HIGH = 8'hA1;
    localparam logic [7:0] RST_CLOCK_LOW = 8'hA5;
    localparam logic [7:0] RST_CRC_ERRORS = 8'h00;
    localparam logic [7:0] RST_FREQ_OVR = 8'h00;
    localparam int OVR_EN_BIT = 7;
    localparam int OVR_VAL_BIT = 6;
    // ****************************************************************
    // timing
    // ****************************************************************
    localparam int CLK_MHZ = 50;
    localparam int UNIT_NS = 40;
    localparam int UNIT_CYC = (UNIT_NS * CLK_MHZ) / 1000;
    typedef enum logic [1:0] {
        PH_IDLE = 2'b00,
        PH_LOW = 2'b01,
        PH_HIGH = 2'b10
    } phase_t;
endpackage

// *** verif/link_peer.sv ***
// Purpose: far side model, sends back channel crc error pulses
// Assumes: bench raises go for one cycle with the pulse count on n
// Notes: one error per cycle, quiet otherwise
`timescale 1ns/1ps
module link_peer (
    input wire logic clk,
    input wire logic go,
    input wire logic [7:0] n,
    output logic crc_error
);
    int left = 0;
    initial crc_error = 1'b0;
    // ****************************************************************
    // error burst
    // ****************************************************************
    // go is taken at the edge, pulses then follow off the edge
    always @(posedge clk) begin
        if (go) begin
            left = n;
        end
        #2;
        crc_error = (left > 0);
        if (left > 0) begin
            left = left - 1;
        end
    end
endmodule

// *** verif/tb_i2c_timing_built_in_self_test_freq_override_regs.sv ***
// Purpose: self-checking bench for ctl_regs against an integer model
// Assumes: one count is two clocks, strap captured shortly after reset
// Notes: small random timing counts keep phases short
`timescale 1ns/1ps
module tb_i2c_timing_built_in_self_test_freq_override_regs;
    logic clk = 0, arst_n = 0, reg_wr = 0, reg_rd = 0, master_en = 0, slave_setup_start = 0;
    logic self_test_pin = 0, freq_strap_pin = 1, go = 0, crc_error;
    logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, n = 8'h00, v;
    logic scl_master_low, scl_stretch, frequency_range_select;
    logic [31:0] lfsr = 32'h9658_3202;
    int fail_count = 0, compares = 0, lo, hi, w;
    // integer model of the register bank
    int m_high = 8'hA1, m_low = 8'hA5, m_err = 8'h00, m_ovr = 8'h00, m_strap = 1;
    int exp_q[$];
    ctl_regs ctl_regs_i (.clk(clk), .arst_n(arst_n), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .master_en(master_en), .scl_master_low(scl_master_low),
        .slave_setup_start(slave_setup_start), .scl_stretch(scl_stretch), .self_test_pin(self_test_pin),
        .crc_error(crc_error), .freq_strap_pin(freq_strap_pin), .frequency_range_select(frequency_range_select));
    link_peer link_peer_i (.clk(clk), .go(go), .n(n), .crc_error(crc_error));
    initial forever #10 clk = ~clk;
    // ****************************************************************
    // helpers
    // ****************************************************************
    function automatic logic [31:0] step(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic tally_and_finish();
        if (fail_count == 0 && compares > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        compares++;
        if (seen !== exp) begin
            fail_count++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        #2 reg_addr = a; reg_wdata = d; reg_wr = 1;
        @(posedge clk);
        #2 reg_wr = 0;
        case (a)
            8'h18: m_high = d;
            8'h19: m_low = d;
            8'h35: m_ovr = d;
            default: ;
        endcase
    endtask
    function automatic logic [7:0] model_read(input logic [7:0] a);
        logic [7:0] r;
        r = 8'h00;
        case (a)
            8'h18: r = 8'(m_high);
            8'h19: r = 8'(m_low);
            8'h1B: r = 8'(m_err);
            8'h35: r = 8'(m_ovr);
            default: ;
        endcase
        return r;
    endfunction
    function automatic logic model_sel();
        return m_ovr[7] ? m_ovr[6] : m_strap[0];
    endfunction
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        exp_q.push_back(int'(model_read(a)));
        @(posedge clk);
        #2 reg_addr = a; reg_rd = 1;
        @(posedge clk);
        #2 reg_rd = 0;
        check("reg_rdata", reg_rdata, exp);
        check("model read", reg_rdata, 8'(exp_q.pop_front()));
    endtask
    task automatic cyc(input int k);
        repeat (k) @(posedge clk);
        #2;
    endtask
    // far side error burst of k pulses, model counts it only in self-test
    task automatic burst(input int k, input int settle);
        n = 8'(k);
        go = 1;
        if (self_test_pin) begin
            m_err = (m_err + k > 255) ? 255 : m_err + k;
        end
        cyc(1);
        go = 0;
        cyc(settle);
    endtask
    // cycles spent at level lv, waiting first for lv
    task automatic width(input bit s, input bit lv, output int c);
        int k;
        k = 0;
        c = 0;
        while ((s ? scl_stretch : scl_master_low) !== lv && k < 600) begin
            cyc(1);
            k++;
        end
        while ((s ? scl_stretch : scl_master_low) === lv && c < 600) begin
            cyc(1);
            c++;
        end
        if (k == 600 || c == 600) begin
            fail_count++;
            tally_and_finish();
        end
    endtask
    // ****************************************************************
    // main sequence
    // ****************************************************************
    initial begin
        cyc(6);
        arst_n = 1;
        cyc(5);
        rd(8'h18, 8'hA1);
        rd(8'h19, 8'hA5);
        rd(8'h1B, 8'h00);
        rd(8'h35, 8'h00);
        rd(8'h20, 8'h00);
        lfsr = step(lfsr);
        lo = 1 + lfsr[1:0];
        lfsr = step(lfsr);
        hi = 1 + lfsr[1:0];
        wr(8'h19, lo[7:0]);
        wr(8'h18, hi[7:0]);
        wr(8'h1B, 8'hFF);
        rd(8'h19, lo[7:0]);
        rd(8'h1B, 8'h00);
        master_en = 1;
        width(0, 1, w);
        check("low phase", w[7:0], 8'(lo * 2));
        width(0, 0, w);
        check("high phase", w[7:0], 8'(hi * 2));
        master_en = 0;
        cyc(20);
        slave_setup_start = 1;
        cyc(1);
        slave_setup_start = 0;
        width(1, 1, w);
        check("stretch", w[7:0], 8'(lo * 2));
        wr(8'h19, 8'h03);
        wr(8'h18, 8'h02);
        master_en = 1;
        width(0, 1, w);
        check("low phase", w[7:0], 8'h06);
        width(0, 0, w);
        check("high phase", w[7:0], 8'h04);
        master_en = 0;
        cyc(20);
        burst(3, 8);
        rd(8'h1B, 8'h00);
        self_test_pin = 1;
        m_err = 0;
        cyc(4);
        burst(5, 10);
        rd(8'h1B, 8'h05);
        self_test_pin = 0;
        cyc(4);
        burst(2, 6);
        rd(8'h1B, 8'h05);
        self_test_pin = 1;
        m_err = 0;
        cyc(5);
        rd(8'h1B, 8'h00);
        burst(250, 252);
        burst(10, 14);
        rd(8'h1B, 8'hFF);
        check("strap select", {7'h00, frequency_range_select}, 8'h01);
        for (int i = 0; i < 4; i++) begin
            v = (i == 0) ? 8'h40 : (i == 1) ? 8'hC0 : (i == 2) ? 8'h80 : 8'h3F;
            wr(8'h35, v);
            cyc(2);
            check("freq select", {7'h00, frequency_range_select}, {7'h00, v[7] ? v[6] : 1'b1});
            check("model select", {7'h00, frequency_range_select}, {7'h00, model_sel()});
            rd(8'h35, v);
        end
        freq_strap_pin = 0;
        cyc(4);
        check("strap held", {7'h00, frequency_range_select}, {7'h00, model_sel()});
        tally_and_finish();
    end
endmodule
